// ---- fp_rounding_denormal_control_tb_top.sv ----
// bench for fprd_ctrl: axi4-lite register tasks, issue and result checks
// assumes fprd_dp_model answers each issue after lat cycles
`timescale 1ns/10ps
module fp_rounding_denormal_control_tb_top;
	import fprd_pkg::*;
	logic        aclk, aresetn;                    // clock, reset
	logic [3:0]  awaddr, araddr, wstrb;            // addresses, strobes
	logic        awvalid, awready, wvalid, wready; // write handshakes
	logic        bvalid, bready, arvalid, arready; // response, read addr
	logic        rvalid, rready;                   // read data
	logic [1:0]  bresp, rresp, res_flags;          // responses, flags
	logic [31:0] wdata, rdata, bool_out;           // words
	logic        iss_valid, iss_ready, op_valid;   // issue side
	logic        raw_valid, res_valid;             // result side
	logic [63:0] opa_out, opb_out, acc_out, res_data; // datapath words
	logic [7:0]  lat;                              // model delay
	fprd_iss_t   iss;                              // offered instruction
	fprd_ctl_t   ctl_out;                          // control out
	fprd_raw_t   raw, pay;                         // result, preload
	int          failures, n_tests;                // counters
	fprd_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .iss_valid,
		.iss_ready, .iss, .op_valid, .opa_out, .opb_out, .acc_out,
		.ctl_out, .bool_out, .raw_valid, .raw, .res_valid, .res_data,
		.res_flags);
	fprd_dp_model dpm (.aclk, .aresetn, .op_valid, .ctl_out, .pay, .lat,
		.raw, .raw_valid);
	always #20 aclk = ~aclk;
	// count a comparison, report a mismatch
	task automatic chk(input logic [95:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic tmo;
		failures++;
		$display("[FAIL] %0t wait ran out", $time);
		summarize();
	endtask : tmo
	// axi write: both channels offered together, each released when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ad, wd;
		int   i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		for (i = 0; i < 20 && !(ad && wd); i++) begin
			@(negedge aclk);
			ad = ad | (awvalid & awready);
			wd = wd | (wvalid & wready);
			@(posedge aclk);
			if (ad)
				awvalid <= 1'b0;
			if (wd)
				wvalid <= 1'b0;
		end
		for (i = 0; i < 20 && bvalid !== 1'b1; i++)
			@(negedge aclk);
		if (bvalid !== 1'b1)
			tmo();
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : axw
	// axi read: address held until taken, rready held until rvalid
	task automatic axr(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge aclk);
		for (i = 0; i < 20 && arready !== 1'b1; i++)
			@(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		@(negedge aclk);
		for (i = 0; i < 20 && rvalid !== 1'b1; i++)
			@(negedge aclk);
		if (rvalid !== 1'b1)
			tmo();
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : axr
	// offer one instruction, count refused cycles, expect op_valid after
	task automatic issue(input fprd_iss_t x, output int st);
		@(posedge aclk);
		iss <= x;
		iss_valid <= 1'b1;
		for (st = 0; st < 40; st++) begin
			@(negedge aclk);
			if (iss_ready === 1'b1)
				break;
		end
		if (st == 40)
			tmo();
		@(posedge aclk);
		iss_valid <= 1'b0;
		iss <= fprd_iss_t'(~x);
		@(negedge aclk);
		chk(op_valid, 1'b1, "no op_valid");
	endtask : issue
	task automatic res(output logic [63:0] d, output logic [1:0] f);
		int i;
		for (i = 0; i < 40 && res_valid !== 1'b1; i++)
			@(negedge aclk);
		if (res_valid !== 1'b1)
			tmo();
		d = res_data;
		f = res_flags;
		@(negedge aclk);
	endtask : res
	function automatic fprd_iss_t mk(input fprd_op_t o,
		input logic [1:0] n, input logic [3:0] fn, input logic [2:0] cr,
		input logic [63:0] a);
		mk = '{o, 1'b1, 1'b1, n, fn, cr, a, 64'h3ff0_0000_0000_0000};
	endfunction : mk
	// increment expected from the mode and sign, lsb, guard, sticky
	function automatic logic rinc(input fprd_rm_t m, input logic s, l, g,
		k);
		case (m)
			RM_NEAR: rinc = g & (k | l);
			RM_POS:  rinc = !s & (g | k);
			RM_NEG:  rinc = s & (g | k);
			default: rinc = 1'b0;
		endcase
	endfunction : rinc
	// register reset values, write back, unmapped places
	task automatic s_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axr(ENV_OFF, d, r);
		chk(d[2:0], {ENV_FF_RST, ENV_RM_RST}, "env reset");
		axr(STAT_OFF, d, r);
		chk(d[5:0], 6'h0, "status reset");
		axw(ENV_OFF, 32'h6, r);
		axr(ENV_OFF, d, r);
		chk({r, d[2:0]}, {RESP_OKAY, 3'h6}, "env write");
		axw(4'hc, 32'h1, r);
		chk(r, RESP_SLVERR, "unmapped write");
		axr(4'h8, d, r);
		chk({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
		axr(ENV_OFF, d, r);
		chk(d[2:0], 3'h6, "env kept");
	endtask : s_regs
	// every mode against ties and sticky-only cases, both signs
	task automatic s_round;
		logic [63:0] d, e;
		logic [1:0]  f, r;
		logic        s, l, g, k;
		int          st;
		for (int m = 0; m < 4; m++) begin
			axw(ENV_OFF, 32'(m), r);
			for (int p = 0; p < 6; p++) begin
				{s, l, g, k} = {p[0], p[1] ^ p[2], ~p[2], p[2]};
				lat = 8'(p);
				pay = {7'h0, s, 11'h400, 51'h0, l, g, k};
				issue(mk(OP_ARITH, 2'h0, 4'h0, 3'h0, 64'h4000_0000_0000_0000), st);
				chk(ctl_out.rm, m, "mode in ctl");
				res(d, f);
				e = {s, 11'h400, 51'h0, l} + 64'(rinc(fprd_rm_t'(m), s, l, g, k));
				chk({f, d}, {1'b0, g | k, e}, "rounded");
			end
		end
	endtask : s_round
	// convert field and mode-free operations
	task automatic s_mode;
		logic [1:0] r;
		int         st;
		fprd_op_t   o;
		lat = 8'h0;
		axw(ENV_OFF, {30'h0, RM_NEG}, r);
		for (int c = 0; c < 8; c++) begin
			issue(mk(OP_CONV, 2'h0, 4'h0, 3'(c), 64'h0), st);
			chk(ctl_out.rm, (c == 4) ? RM_NEG : 2'(c), "convert mode");
		end
		axw(ENV_OFF, {30'h0, RM_ZERO}, r);
		for (int i = 0; i < 4; i++) begin
			o = (i == 0) ? OP_CMP : (i == 1) ? OP_CLASS : OP_SDMUL;
			o = (i == 3) ? OP_ARITH : o;
			issue(mk(o, 2'h0, 4'h0, 3'h0, 64'h0), st);
			chk(ctl_out.rm, (i == 3) ? RM_ZERO : RM_NEAR, "fixed mode");
		end
	endtask : s_mode
	// operand flush, tiny result, slow full denormal, forced flush
	task automatic s_flush;
		logic [63:0] d;
		logic [31:0] w;
		logic [1:0]  f, r;
		int          st;
		fprd_iss_t   x;
		pay = {7'h0, 1'b0, 11'h400, 52'h0, 2'b00};
		axw(ENV_OFF, 32'h4, r);
		issue(mk(OP_ARITH, 2'h0, 4'h0, 3'h0, 64'h8000_0000_0000_0001), st);
		chk({2'(st), ctl_out.flush, opa_out}, {3'h1, 64'h8000_0000_0000_0000}, "flush a");
		res(d, f);
		chk(f, 2'b00, "operand flush flagged");
		pay = {7'h0, 1'b1, 11'h0, 52'h1, 2'b00};
		issue(mk(OP_ARITH, 2'h0, 4'h0, 3'h0, 64'h0), st);
		res(d, f);
		chk({f, d}, {2'b11, 64'h8000_0000_0000_0000}, "tiny result");
		axr(STAT_OFF, w, r);
		chk(w[5:4], 2'b11, "sticky flags");
		axw(STAT_OFF, 32'h30, r);
		axr(STAT_OFF, w, r);
		chk(w[5:4], 2'b00, "sticky clear");
		x = mk(OP_ARITH, 2'h0, 4'h0, 3'h0, 64'h0000_0000_0000_0005);
		x.dbl = 1'b0;
		x.b = 64'h3ff0_0000_8000_0003;
		issue(x, st);
		chk(opa_out[31:0], 32'h0, "single flush");
		chk(opb_out, 64'h3ff0_0000_8000_0000, "single flush b");
		res(d, f);
		axw(ENV_OFF, 32'h0, r);
		issue(mk(OP_ARITH, 2'h0, 4'h0, 3'h0, 64'h8000_0000_0000_0001), st);
		chk({2'(st), ctl_out.flush, opa_out}, {2'(DN_EXTRA), 1'b0, 64'h8000_0000_0000_0001}, "full denormal");
		res(d, f);
		issue(mk(OP_MAC, 2'h2, 4'h0, 3'h0, 64'h8000_0000_0000_0001), st);
		chk({2'(st), ctl_out.flush, opa_out}, {3'h1, 64'h8000_0000_0000_0000}, "mac flush");
		res(d, f);
		issue(mk(OP_MTACC, 2'h3, 4'h0, 3'h0, 64'h8000_0000_0000_0001), st);
		chk(opa_out, 64'h8000_0000_0000_0000, "mtacc flush");
		res(d, f);
	endtask : s_flush
	// independent accumulators, stall on busy, init ignores old value
	task automatic s_acc;
		logic [31:0] w;
		logic [1:0]  r;
		int          st;
		fprd_iss_t   x;
		lat = 8'd14;
		pay = {7'h0, 1'b0, 11'h3ff, 52'h1, 2'b00};
		issue(mk(OP_MAC, 2'h0, 4'h0, 3'h0, 64'h0), st);
		// the model takes pay at the next edge; change it only after that
		@(negedge aclk);
		pay = {7'h0, 1'b0, 11'h401, 52'h0, 2'b00};
		issue(mk(OP_MSM, 2'h1, 4'h0, 3'h0, 64'h0), st);
		chk(st, 0, "independent acc stalled");
		axr(STAT_OFF, w, r);
		chk(w[3:0], 4'h3, "busy bits");
		lat = 8'd0;
		issue(mk(OP_MFACC, 2'h0, 4'h0, 3'h0, 64'h0), st);
		chk({st > 0, acc_out}, {1'b1, 64'h3ff0_0000_0000_0001}, "first_fp_accumulator read");
		issue(mk(OP_MFACC, 2'h1, 4'h0, 3'h0, 64'h0), st);
		chk(acc_out, 64'h4010_0000_0000_0000, "acc1 read");
		x = mk(OP_MAC, 2'h0, MAC_FUNC_INIT, 3'h0, 64'h0);
		x.dbl = 1'b0;
		issue(x, st);
		chk({ctl_out.dbl, ctl_out.acc_wr, ctl_out.acc_num, acc_out}, {4'hc, 64'h0}, "mac init");
	endtask : s_acc
	// ge-zero boolean in the msb only
	task automatic s_bool;
		int st;
		issue(mk(OP_GEZ, 2'h0, 4'h0, 3'h0, 64'h0000_0000_8000_0001), st);
		chk(bool_out[31], 1'b0, "ge zero of negative");
		issue(mk(OP_GEZ, 2'h0, 4'h0, 3'h0, 64'h0000_0000_7fff_fffe), st);
		chk(bool_out[31], 1'b1, "ge zero of positive");
	endtask : s_bool
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, araddr, wstrb, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready, iss_valid} = '0;
		iss = '0;
		pay = '0;
		lat = 8'h0;
		failures = 0;
		n_tests = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		s_regs();
		s_round();
		s_mode();
		s_flush();
		s_acc();
		s_bool();
		summarize();
	end
endmodule : fp_rounding_denormal_control_tb_top

// ---- fprd_ctrl.sv ----
// fprd_ctrl: rounding, denormal flush and fp accumulators of the fpu
// assumes issue logic and datapath share aclk; axi4-lite slave for regs
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// - nearest rounding, ties pick even lsb
// - toward plus infinity rounds up
// - toward minus infinity rounds down
// - toward zero truncates magnitude
// - env field sets mode for arithmetic
// - convert uses env mode only for 100
// - compare, class, widening multiply ignore mode
// - flush select bit enables fast float
// - denormal source becomes signed zero
// - operand flush raises no inexact
// - operand flush costs no cycles
// - tiny result flushes, underflow and inexact
// - mac, multiply-sum and move-to-accumulator always flush denormals
// - full denormals may take extra cycles
// - four accumulators selected by number
// - accumulator format independent of operands
// - function four ignores old accumulator
// - stall on busy accumulator only
// - boolean lives in the msb
// - ge-zero gives complement of boolean
module fprd_ctrl #(
	parameter int NACC = 4 // accumulator count
) (
	input  wire logic              aclk,     // 25 MHz clock
	input  wire logic              aresetn,  // sync reset, low
	input  wire logic [3:0]        awaddr,   // write address
	input  wire logic              awvalid,  // write address valid
	output logic                   awready,  // write address ready
	input  wire logic [31:0]       wdata,    // write data
	input  wire logic [3:0]        wstrb,    // write strobes
	input  wire logic              wvalid,   // write data valid
	output logic                   wready,   // write data ready
	output logic [1:0]             bresp,    // write response
	output logic                   bvalid,   // write response valid
	input  wire logic              bready,   // write response ready
	input  wire logic [3:0]        araddr,   // read address
	input  wire logic              arvalid,  // read address valid
	output logic                   arready,  // read address ready
	output logic [31:0]            rdata,    // read data
	output logic [1:0]             rresp,    // read response
	output logic                   rvalid,   // read data valid
	input  wire logic              rready,   // read data ready
	input  wire logic              iss_valid,// instruction offered
	output logic                   iss_ready,// instruction taken
	input  wire fprd_pkg::fprd_iss_t iss,    // instruction
	output logic                   op_valid, // operands out valid
	output logic [63:0]            opa_out,  // flushed operand a
	output logic [63:0]            opb_out,  // flushed operand b
	output logic [63:0]            acc_out,  // accumulator operand
	output fprd_pkg::fprd_ctl_t    ctl_out,  // control for datapath
	output logic [31:0]            bool_out, // ge-zero boolean
	input  wire logic              raw_valid,// unrounded result valid
	input  wire fprd_pkg::fprd_raw_t raw,    // unrounded result
	output logic                   res_valid,// rounded result valid
	output logic [63:0]            res_data, // rounded result
	output logic [1:0]             res_flags // {underflow, inexact}
);
	import fprd_pkg::*;

	// elaboration guard: scoreboard and status map hold four accumulators
	if (NACC != 4) begin : g_nacc_bad
		$error("fprd_ctrl serves exactly four accumulators");
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// true when v holds a denormal of the given precision
	function automatic logic is_dn(input logic [63:0] v, input logic d);
		if (d)
			return (v[62:52] == 11'h0) && (v[51:0] != 52'h0);
		return (v[30:23] == 8'h0) && (v[22:0] != 23'h0);
	endfunction : is_dn

	// denormal to zero of same sign, anything else untouched
	function automatic logic [63:0] flush_v(input logic [63:0] v,
			input logic d, input logic f);
		if (!(f && is_dn(v, d)))
			return v;
		if (d)
			return {v[63], 63'h0};
		return {v[63:32], v[31], 31'h0};
	endfunction : flush_v

	// increment decision of the four modes
	function automatic logic rnd_up(input fprd_rm_t m, input logic s,
			input logic l, input logic g, input logic k);
		case (m)
			RM_NEAR: return g && (k || l);
			RM_POS:  return !s && (g || k);
			RM_NEG:  return s && (g || k);
			RM_ZERO: return 1'b0;
			default: return 1'b0;
		endcase
	endfunction : rnd_up

	// accumulator ops
	function automatic logic acc_op(input fprd_op_t o);
		return o inside {OP_MAC, OP_MSM, OP_MTACC, OP_MFACC};
	endfunction : acc_op

	logic [1:0]     env_rm_r;    // rounding_mode_field
	logic           env_ff_r;    // denormal_flush_select
	logic [NACC-1:0] busy_r;     // accumulator being produced
	logic           uf_r;        // sticky underflow
	logic           nx_r;        // sticky inexact
	logic [63:0]    acc_r [NACC];// first..last_fp_accumulator
	logic [1:0]     slow_cnt_r;  // extra denormal cycles spent
	logic           fire;        // instruction taken
	logic           flush_eff;   // flush for this instruction
	logic           slow_need;   // full denormal path needed
	logic           hazard;      // accumulator not ready
	logic           wr_acc;      // instruction writes accumulator
	fprd_rm_t       rm_eff;      // mode for this instruction
	logic           aw_got_r;    // write address held
	logic           w_got_r;     // write data held
	logic [3:0]     awaddr_r;    // held write address
	logic [31:0]    wdata_r;     // held write data
	logic           wstb_r;      // held lane 0 strobe
	logic           do_wr;       // write performs now
	logic           stat_w1c;    // status write this cycle
	logic           r_tiny;      // result below normal range
	logic           r_inx;       // result inexact
	logic           r_up;        // round increments
	logic [63:0]    r_trunc;     // packed truncated result
	logic [63:0]    r_round;     // packed rounded result

	assign flush_eff = env_ff_r || (iss.op inside {OP_MTACC, OP_MAC, OP_MSM});
	assign wr_acc = iss.op inside {OP_MAC, OP_MSM, OP_MTACC};
	// stall only on the accumulator in use
	assign hazard = acc_op(iss.op) && busy_r[iss.acc_num];
	assign slow_need = !flush_eff
		&& (is_dn(iss.a, iss.dbl) || is_dn(iss.b, iss.dbl));
	assign iss_ready = !hazard && (!slow_need || slow_cnt_r == 2'(DN_EXTRA));
	assign fire = iss_valid && iss_ready;

	// mode selection per operation
	always_comb begin
		rm_eff = fprd_rm_t'(env_rm_r);
		// convert mode from field unless 100
		if (iss.op == OP_CONV && iss.conv_rnd != CONV_USE_ENV)
			rm_eff = fprd_rm_t'(iss.conv_rnd[1:0]);
		if (iss.op inside {OP_CMP, OP_CLASS, OP_SDMUL})
			rm_eff = RM_NEAR;
	end

	// slow denormal cycle counter
	always_ff @(posedge aclk) begin
		if (!aresetn || fire || !slow_need)
			slow_cnt_r <= 2'h0;
		else if (iss_valid && !hazard && slow_cnt_r != 2'(DN_EXTRA))
			slow_cnt_r <= slow_cnt_r + 2'h1;
	end

	// operand stage toward the datapath
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_valid <= 1'b0;
			opa_out  <= 64'h0;
			opb_out  <= 64'h0;
			acc_out  <= 64'h0;
			ctl_out  <= '0;
			bool_out <= 32'h0;
		end else begin
			op_valid <= fire;
			if (fire) begin
				// zero of same sign, no flag
				opa_out <= flush_v(iss.a, iss.dbl, flush_eff);
				opb_out <= flush_v(iss.b, iss.dbl, flush_eff);
				if (iss.op == OP_MAC && iss.mac_func == MAC_FUNC_INIT)
					acc_out <= 64'h0;
				else
					acc_out <= acc_r[iss.acc_num];
				ctl_out.rm      <= rm_eff;
				ctl_out.flush   <= flush_eff;
				ctl_out.dbl     <= wr_acc ? iss.acc_dbl : iss.dbl;
				ctl_out.acc_wr  <= wr_acc;
				ctl_out.acc_num <= iss.acc_num;
				bool_out <= {~iss.a[31], 31'h0};
			end
		end
	end

	// result rounding, tiny detection
	always_comb begin
		r_tiny = raw.exp == 11'h0 && (raw.frac != 52'h0 || raw.grd || raw.stk);
		r_inx = raw.grd || raw.stk;
		r_up = rnd_up(raw.ctl.rm, raw.sign, raw.frac[0], raw.grd, raw.stk);
		if (raw.ctl.dbl)
			r_trunc = {raw.sign, raw.exp, raw.frac};
		else
			r_trunc = {32'h0, raw.sign, raw.exp[7:0], raw.frac[22:0]};
		// carry into the exponent field is the intended renormalise
		if (raw.ctl.dbl)
			r_round = {r_trunc[63], r_trunc[62:0] + 63'(r_up)};
		else
			r_round = {32'h0, r_trunc[31], r_trunc[30:0] + 31'(r_up)};
	end

	// result register and flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_valid <= 1'b0;
			res_data  <= 64'h0;
			res_flags <= 2'h0;
		end else begin
			res_valid <= raw_valid;
			if (raw_valid) begin
				if (raw.ctl.flush && r_tiny) begin
					res_data  <= raw.ctl.dbl ? {raw.sign, 63'h0}
						: {32'h0, raw.sign, 31'h0};
					res_flags <= 2'h3;
				end else begin
					res_data  <= r_round;
					res_flags <= {r_tiny && r_inx, r_inx};
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NACC; i++)
				acc_r[i] <= 64'h0;
		end else if (raw_valid && raw.ctl.acc_wr) begin
			acc_r[raw.ctl.acc_num] <= (raw.ctl.flush && r_tiny)
				? (raw.ctl.dbl ? {raw.sign, 63'h0} : {32'h0, raw.sign, 31'h0})
				: r_round;
		end
	end

	// busy scoreboard, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			busy_r <= '0;
		else
			busy_r <= (busy_r & ~((raw_valid && raw.ctl.acc_wr)
				? NACC'(1) << raw.ctl.acc_num : NACC'(0)))
				| ((fire && wr_acc) ? NACC'(1) << iss.acc_num : NACC'(0));
	end

	// axi write channel capture
	assign awready = !aw_got_r && !bvalid;
	assign wready  = !w_got_r && !bvalid;
	assign do_wr   = aw_got_r && w_got_r && !bvalid;
	assign stat_w1c = do_wr && awaddr_r == STAT_OFF && wstb_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r  <= 32'h0;
			wstb_r   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wdata_r <= wdata;
				wstb_r  <= wstrb[0];
			end
			if (do_wr) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= (awaddr_r == ENV_OFF || awaddr_r == STAT_OFF)
					? RESP_OKAY : RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end

	// env register, software steers mode and flush
	// two-bit mode code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			env_rm_r <= ENV_RM_RST;
			env_ff_r <= ENV_FF_RST;
		end else if (do_wr && awaddr_r == ENV_OFF && wstb_r) begin
			env_rm_r <= wdata_r[ENV_RM_POS +: 2];
			env_ff_r <= wdata_r[ENV_FF_POS];
		end
	end

	// sticky flags, write one clears, a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uf_r <= 1'b0;
			nx_r <= 1'b0;
		end else begin
			uf_r <= (uf_r && !(stat_w1c && wdata_r[STAT_UF_POS]))
				|| (res_valid && res_flags[1]);
			nx_r <= (nx_r && !(stat_w1c && wdata_r[STAT_NX_POS]))
				|| (res_valid && res_flags[0]);
		end
	end

	// axi read channel
	assign arready = !rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			case (araddr)
				ENV_OFF:  rdata <= 32'({env_ff_r, env_rm_r});
				STAT_OFF: rdata <= 32'({nx_r, uf_r, busy_r});
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rready)
			rvalid <= 1'b0;
	end

	AST_CONV_ENV: assert property (
		fire && iss.op == OP_CONV && iss.conv_rnd == CONV_USE_ENV
		|=> ctl_out.rm == fprd_rm_t'($past(env_rm_r)))
		else $error("convert 100 did not take env mode");
	AST_MODE_BLIND: assert property (
		fire && iss.op inside {OP_CMP, OP_CLASS, OP_SDMUL}
		|=> ctl_out.rm == RM_NEAR)
		else $error("mode-blind op carried env mode");
	AST_ACC_FLUSH: assert property (
		fire && iss.op inside {OP_MAC, OP_MSM, OP_MTACC}
		|=> op_valid && ctl_out.flush)
		else $error("accumulator op not flushed");
	AST_OPND_ZERO: assert property (
		fire && flush_eff && iss.dbl && is_dn(iss.a, 1'b1)
		|=> opa_out == {$past(iss.a[63]), 63'h0})
		else $error("denormal operand not signed zero");
	AST_TINY: assert property (
		raw_valid && raw.ctl.flush && r_tiny && raw.ctl.dbl
		|=> res_flags == 2'h3 && res_data[62:0] == 63'h0)
		else $error("tiny result not flushed with flags");
	AST_TRUNC: assert property (
		raw_valid && raw.ctl.rm == RM_ZERO && !r_tiny
		|=> res_data == $past(r_trunc))
		else $error("toward zero did not truncate");
	AST_INIT: assert property (
		fire && iss.op == OP_MAC && iss.mac_func == MAC_FUNC_INIT
		|=> acc_out == 64'h0)
		else $error("init mac read old accumulator");
	AST_HAZ: assert property (
		iss_valid && acc_op(iss.op) && busy_r[iss.acc_num] |-> !iss_ready)
		else $error("busy accumulator not stalled");
	AST_FAST: assert property (
		iss_valid && flush_eff && !hazard |-> iss_ready)
		else $error("flushed operand delayed issue");
	AST_SLOW: assert property (
		iss_valid && slow_need && !hazard && slow_cnt_r == 2'h0
		|-> !iss_ready ##1 !iss_ready ##1 iss_ready)
		else $error("slow denormal timing wrong");
	AST_GEZ: assert property (
		fire && iss.op == OP_GEZ |=> bool_out[31] == !$past(iss.a[31]))
		else $error("ge-zero not complement");
endmodule : fprd_ctrl

// ---- fprd_dp_model.sv ----
// fprd_dp_model: behavioural datapath standing beyond the control unit
// assumes the bench preloads pay and lat before each issue is taken
`timescale 1ns/10ps
module fprd_dp_model (
	input  wire logic                aclk,      // clock
	input  wire logic                aresetn,   // sync reset, low
	input  wire logic                op_valid,  // operands issued
	input  wire fprd_pkg::fprd_ctl_t ctl_out,   // control to echo
	input  wire fprd_pkg::fprd_raw_t pay,       // result fields to return
	input  wire logic [7:0]          lat,       // answer delay in cycles
	output fprd_pkg::fprd_raw_t      raw,       // unrounded result
	output logic                     raw_valid  // result strobe
);
	import fprd_pkg::*;
	fprd_raw_t q[$];   // results in flight
	int        due[$]; // answer cycle of each
	int        cyc;    // running cycle count
	fprd_raw_t r;      // result being queued
	initial begin
		cyc = 0;
		raw = '0;
		raw_valid = 1'b0;
	end
	// queue each issue, answer it lat cycles later, one per cycle
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (!aresetn) begin
			q.delete();
			due.delete();
		end else if (op_valid) begin
			r = pay;
			r.ctl = ctl_out;
			q.push_back(r);
			due.push_back(cyc + int'(lat));
		end
		// idle bus inverts every bit each cycle, so the last result returns every other cycle
		if (due.size() > 0 && due[0] <= cyc) begin
			raw <= q.pop_front();
			void'(due.pop_front());
			raw_valid <= 1'b1;
		end else begin
			raw <= fprd_raw_t'(~raw);
			raw_valid <= 1'b0;
		end
	end
endmodule : fprd_dp_model

// ---- fprd_pkg.sv ----
// fprd_pkg: constants, codes and carriers of the fp rounding/denormal unit
// assumes one clock domain; shared by the control module and the bench
package fprd_pkg;
	// rounding-mode codes in the env register field
	typedef enum logic [1:0] {
		RM_NEAR = 2'h0, // nearest, ties to even
		RM_POS  = 2'h1, // toward +inf
		RM_NEG  = 2'h2, // toward -inf
		RM_ZERO = 2'h3  // truncate
	} fprd_rm_t;
	// operation classes seen at issue
	typedef enum logic [3:0] {
		OP_ARITH = 4'h0, // add sub mul div sqrt
		OP_MAC   = 4'h1, // multiply-accumulate
		OP_MSM   = 4'h2, // multiply-sum
		OP_MTACC = 4'h3, // move to accumulator
		OP_MFACC = 4'h4, // move from accumulator
		OP_CONV  = 4'h5, // format convert
		OP_CMP   = 4'h6, // compare
		OP_CLASS = 4'h7, // classify
		OP_SDMUL = 4'h8, // single_to_double_multiply
		OP_GEZ   = 4'h9  // signed >= 0 boolean
	} fprd_op_t;
	localparam logic [2:0]  CONV_USE_ENV  = 3'h4;  // convert_round_field
	localparam logic [3:0]  MAC_FUNC_INIT = 4'h4;  // product plus 0.0
	localparam logic [3:0]  ENV_OFF       = 4'h0;  // env register
	localparam logic [3:0]  STAT_OFF      = 4'h4;  // status register
	localparam int          ENV_RM_POS    = 0;     // rounding_mode_field
	localparam int          ENV_FF_POS    = 2;     // denormal_flush_select
	localparam int          STAT_BUSY_POS = 0;     // accumulator busy [3:0]
	localparam int          STAT_UF_POS   = 4;     // sticky underflow
	localparam int          STAT_NX_POS   = 5;     // sticky inexact
	localparam logic [1:0]  ENV_RM_RST    = 2'h0;  // nearest after reset
	localparam logic        ENV_FF_RST    = 1'b0;  // full denormals
	localparam int          DN_EXTRA      = 2;     // slow denormal cycles
	localparam logic [1:0]  RESP_OKAY     = 2'h0;  // axi okay
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;  // axi slave error
	// issued instruction
	typedef struct packed {
		fprd_op_t    op;       // class
		logic        dbl;      // operand precision
		logic        acc_dbl;  // accumulator precision
		logic [1:0]  acc_num;  // accumulator select
		logic [3:0]  mac_func; // mac function field
		logic [2:0]  conv_rnd; // convert_round_field
		logic [63:0] a;        // source a
		logic [63:0] b;        // source b
	} fprd_iss_t;
	// control carried down the datapath and echoed back
	typedef struct packed {
		fprd_rm_t    rm;       // effective mode
		logic        flush;    // effective flush
		logic        dbl;      // result precision
		logic        acc_wr;   // result goes to accumulator
		logic [1:0]  acc_num;  // target accumulator
	} fprd_ctl_t;
	// unrounded result from the datapath
	typedef struct packed {
		fprd_ctl_t   ctl;      // echoed control
		logic        sign;     // sign
		logic [10:0] exp;      // biased exp, 0 when tiny
		logic [51:0] frac;     // fraction, single in [22:0]
		logic        grd;      // guard bit
		logic        stk;      // sticky bit
	} fprd_raw_t;
endpackage : fprd_pkg
